// ---- design/ocsp_pkg.sv ----
// Shared constants and types for the overhead channel serial port
package ocsp_pkg;
	// Interface type codes, one setting for both directions
	localparam logic [1:0] OCSP_IF_RS232     = 2'h0;
	localparam logic [1:0] OCSP_IF_GATED_4W  = 2'h1;
	localparam logic [1:0] OCSP_IF_ALWAYS_ON = 2'h2;
	localparam logic [1:0] OCSP_IF_TWO_WIRE  = 2'h3;
	// Multiplexer frame modes
	localparam logic [1:0] OCSP_MODE_STD    = 2'h0;
	localparam logic [1:0] OCSP_MODE_ENH    = 2'h1;
	localparam logic [1:0] OCSP_MODE_CUSTOM = 2'h2;
	// Buffer fill thresholds in quarters of capacity
	localparam int OCSP_FILL_HI_Q = 3;
	localparam int OCSP_FILL_LO_Q = 1;
	localparam int OCSP_BUF_BYTES = 2048;
	// Character format: data bits are 5 plus the configured code
	localparam logic [3:0] OCSP_MIN_BITS = 4'h5;
	localparam logic [15:0] OCSP_DIV_RST = 16'h0001;
	typedef enum logic [4:0] {
		OCSP_IDLE  = 5'h01,
		OCSP_START = 5'h02,
		OCSP_DATA  = 5'h04,
		OCSP_PAR   = 5'h08,
		OCSP_STOP  = 5'h10
	} ocsp_ser_t;
endpackage

// ---- design/ocsp_port.sv ----
// Overhead channel serial port: buffers, character framing, line control
// Operation
// - Interface type chosen by software: RS-232, gated 4-wire, always-on, 2-wire
// - Always-on setting keeps the RS-485 driver enabled continuously
// - Gated 4-wire setting tri-states the driver when not sending
// - Standard frame mode allows only always-on driver and 4-wire receive
// - Two-wire receive selectable only in enhanced or custom mode
// - Two-wire mode mutes receive input while own output is active
// - Four-wire mode keeps receive input enabled at all times
// - Standard mode runs RS-232 synchronous, unbuffered, at the frame rate
// - Enhanced and custom modes buffer both ways and run asynchronously
// - Rate, type, wire count and format shared by both directions
// - One transceiver type serves both directions
// - RTS/CTS and DTR/DSR honoured only in RS-232 mode, if enabled
// - CTS drops when transmit buffer reaches three quarters full
// - CTS returns once transmit buffer is one quarter full or less
// - DTR low halts receive data output, buffer keeps filling
// - Normal DSR is asserted while received data is present
// - CTS may be forced asserted, else follows the thresholds
// - DSR may be forced asserted, else follows DTR and data presence
// - Normal DSR also drops on lost lock or multiplexer alarm
// - DTR ignore setting disregards DTR and removes receive flow control
// - Each buffer holds 2048 bytes in first-in first-out order
`timescale 1ns/1ps
`default_nettype none
module ocsp_port
	import ocsp_pkg::*;
#(
	parameter int DEPTH = OCSP_BUF_BYTES
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [1:0]  frame_mode,
	input  wire logic [1:0]  iface_type,
	input  wire logic [15:0] bit_div,
	input  wire logic [1:0]  data_bits,
	input  wire logic        parity_en,
	input  wire logic        parity_odd,
	input  wire logic        stop_two,
	input  wire logic        flow_enable,
	input  wire logic        cts_force,
	input  wire logic        dsr_force,
	input  wire logic        dtr_ignore,
	input  wire logic        demod_lock,
	input  wire logic        mux_alarm,
	input  wire logic        term_txd,
	input  wire logic        term_rts,
	input  wire logic        term_dtr,
	output logic             term_rxd,
	output logic             term_rxd_oe,
	output logic             term_cts,
	output logic             term_dsr,
	output logic             mux_tx_valid,
	input  wire logic        mux_tx_ready,
	output logic [7:0]       mux_tx_data,
	input  wire logic        mux_rx_valid,
	input  wire logic [7:0]  mux_rx_data,
	output logic             mux_sync_tx,
	input  wire logic        mux_sync_rx,
	output logic             parity_error,
	output logic             framing_error,
	output logic             tx_overflow,
	output logic             rx_overflow,
	output logic [$clog2(DEPTH):0] tx_fill,
	output logic [$clog2(DEPTH):0] rx_fill
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FILL_HI = (AW+1)'(DEPTH * OCSP_FILL_HI_Q / 4);
	localparam logic [AW:0] FILL_LO = (AW+1)'(DEPTH * OCSP_FILL_LO_Q / 4);

	typedef struct packed {
		logic [DEPTH-1:0][7:0] txm;
		logic [AW-1:0]         tx_wr;
		logic [AW-1:0]         tx_rd;
		logic [AW:0]           tx_cnt;
		logic [DEPTH-1:0][7:0] rxm;
		logic [AW-1:0]         rx_wr;
		logic [AW-1:0]         rx_rd;
		logic [AW:0]           rx_cnt;
		logic                  cts;
		ocsp_ser_t             ds;
		logic [15:0]           ds_tmr;
		logic [3:0]            ds_bit;
		logic [7:0]            ds_sh;
		logic                  ds_par;
		ocsp_ser_t             sr;
		logic [15:0]           sr_tmr;
		logic [3:0]            sr_bit;
		logic [7:0]            sr_sh;
		logic                  sr_par;
		logic                  sr_stop2;
		logic                  rxd;
		logic                  sync_tx;
		logic                  perr;
		logic                  ferr;
		logic                  tx_ovf;
		logic                  rx_ovf;
	} ocsp_state_t;

	ocsp_state_t st;
	ocsp_state_t next_st;

	// Data bit count decoded from the shared format code
	function automatic logic [3:0] ocsp_nbits(input logic [1:0] code);
		return OCSP_MIN_BITS + {2'h0, code};
	endfunction

	// Standard mode pins the driver on and the receive to four wires
	logic std_mode;
	logic [1:0] eff_type;
	logic rs232;
	logic flow_on;
	logic two_wire;
	logic dtr_hold;
	logic ds_line;
	logic ds_push;
	logic tx_pop;
	logic sr_pop;
	logic [3:0] nbits;
	logic [15:0] div;

	always_comb begin
		std_mode = (frame_mode == OCSP_MODE_STD);
		eff_type = iface_type;
		if (std_mode && iface_type != OCSP_IF_RS232)
			eff_type = OCSP_IF_ALWAYS_ON;
		rs232 = (eff_type == OCSP_IF_RS232);
		flow_on = rs232 && flow_enable;
		two_wire = (eff_type == OCSP_IF_TWO_WIRE);
		dtr_hold = flow_on && !dtr_ignore && !term_dtr;
		nbits = ocsp_nbits(data_bits);
		div = (bit_div == 16'h0000) ? OCSP_DIV_RST : bit_div;
		// Own output active mutes a shared pair; 4-wire always listens
		ds_line = (two_wire && st.sr != OCSP_IDLE) ? 1'b1 : term_txd;
		// Terminal holding RTS low is treated as nothing to send
		if (flow_on && !term_rts)
			ds_line = 1'b1;
	end

	always_comb begin
		next_st = st;
		next_st.perr = 1'b0;
		next_st.ferr = 1'b0;
		next_st.tx_ovf = 1'b0;
		next_st.rx_ovf = 1'b0;
		ds_push = 1'b0;
		sr_pop = 1'b0;
		tx_pop = mux_tx_valid && mux_tx_ready;
		next_st.sync_tx = term_txd;

		// Receive from the terminal: start, data, parity, stop
		if (std_mode) begin
			next_st.ds = OCSP_IDLE;
		end else begin
			unique case (st.ds)
			OCSP_IDLE: begin
				if (!ds_line) begin
					next_st.ds = OCSP_START;
					next_st.ds_tmr = div >> 1;
				end
			end
			OCSP_START: begin
				if (st.ds_tmr == 16'h0000) begin
					next_st.ds = ds_line ? OCSP_IDLE : OCSP_DATA;
					next_st.ds_tmr = div - 16'h0001;
					next_st.ds_bit = 4'h0;
					next_st.ds_par = 1'b0;
				end else begin
					next_st.ds_tmr = st.ds_tmr - 16'h0001;
				end
			end
			OCSP_DATA: begin
				if (st.ds_tmr == 16'h0000) begin
					next_st.ds_sh = {ds_line, st.ds_sh[7:1]};
					next_st.ds_par = st.ds_par ^ ds_line;
					next_st.ds_bit = st.ds_bit + 4'h1;
					next_st.ds_tmr = div - 16'h0001;
					if (st.ds_bit == nbits - 4'h1)
						next_st.ds = parity_en ? OCSP_PAR : OCSP_STOP;
				end else begin
					next_st.ds_tmr = st.ds_tmr - 16'h0001;
				end
			end
			OCSP_PAR: begin
				if (st.ds_tmr == 16'h0000) begin
					next_st.perr = (st.ds_par ^ ds_line) != parity_odd;
					next_st.ds = OCSP_STOP;
					next_st.ds_tmr = div - 16'h0001;
				end else begin
					next_st.ds_tmr = st.ds_tmr - 16'h0001;
				end
			end
			OCSP_STOP: begin
				if (st.ds_tmr == 16'h0000) begin
					// Only the first stop bit is checked on input
					next_st.ds = OCSP_IDLE;
					if (ds_line)
						ds_push = 1'b1;
					else
						next_st.ferr = 1'b1;
				end else begin
					next_st.ds_tmr = st.ds_tmr - 16'h0001;
				end
			end
			default: next_st.ds = OCSP_IDLE;
			endcase
		end

		// Transmit buffer, terminal to multiplexer
		if (ds_push && st.tx_cnt == (AW+1)'(DEPTH)) begin
			// Overflow purges everything; sender ignored CTS
			next_st.tx_cnt = '0;
			next_st.tx_rd = st.tx_wr;
			next_st.tx_ovf = 1'b1;
		end else begin
			if (ds_push) begin
				next_st.txm[st.tx_wr] = st.ds_sh >> (4'h8 - nbits);
				next_st.tx_wr = st.tx_wr + 1'b1;
			end
			if (tx_pop)
				next_st.tx_rd = st.tx_rd + 1'b1;
			next_st.tx_cnt = st.tx_cnt + (AW+1)'(ds_push) - (AW+1)'(tx_pop);
		end

		// CTS hysteresis against the transmit fill level
		if (next_st.tx_cnt >= FILL_HI)
			next_st.cts = 1'b0;
		else if (next_st.tx_cnt <= FILL_LO)
			next_st.cts = 1'b1;

		// Send to the terminal from the receive buffer
		if (std_mode) begin
			next_st.sr = OCSP_IDLE;
			next_st.rxd = mux_sync_rx;
		end else begin
			unique case (st.sr)
			OCSP_IDLE: begin
				next_st.rxd = 1'b1;
				if (st.rx_cnt != '0 && !dtr_hold) begin
					sr_pop = 1'b1;
					next_st.sr_sh = st.rxm[st.rx_rd];
					next_st.sr = OCSP_START;
					next_st.sr_tmr = div - 16'h0001;
					next_st.sr_bit = 4'h0;
					next_st.sr_par = 1'b0;
					next_st.sr_stop2 = 1'b0;
					next_st.rxd = 1'b0;
				end
			end
			OCSP_START: begin
				if (st.sr_tmr == 16'h0000) begin
					next_st.sr = OCSP_DATA;
					next_st.sr_tmr = div - 16'h0001;
					next_st.rxd = st.sr_sh[0];
					next_st.sr_par = st.sr_sh[0];
					next_st.sr_sh = st.sr_sh >> 1;
				end else begin
					next_st.sr_tmr = st.sr_tmr - 16'h0001;
				end
			end
			OCSP_DATA: begin
				if (st.sr_tmr == 16'h0000) begin
					next_st.sr_tmr = div - 16'h0001;
					next_st.sr_bit = st.sr_bit + 4'h1;
					if (st.sr_bit == nbits - 4'h1) begin
						next_st.sr = parity_en ? OCSP_PAR : OCSP_STOP;
						next_st.rxd = parity_en ?
							(st.sr_par ^ parity_odd) : 1'b1;
					end else begin
						next_st.rxd = st.sr_sh[0];
						next_st.sr_par = st.sr_par ^ st.sr_sh[0];
						next_st.sr_sh = st.sr_sh >> 1;
					end
				end else begin
					next_st.sr_tmr = st.sr_tmr - 16'h0001;
				end
			end
			OCSP_PAR: begin
				if (st.sr_tmr == 16'h0000) begin
					next_st.sr = OCSP_STOP;
					next_st.sr_tmr = div - 16'h0001;
					next_st.rxd = 1'b1;
				end else begin
					next_st.sr_tmr = st.sr_tmr - 16'h0001;
				end
			end
			OCSP_STOP: begin
				if (st.sr_tmr == 16'h0000) begin
					if (stop_two && !st.sr_stop2) begin
						next_st.sr_stop2 = 1'b1;
						next_st.sr_tmr = div - 16'h0001;
					end else begin
						next_st.sr = OCSP_IDLE;
					end
				end else begin
					next_st.sr_tmr = st.sr_tmr - 16'h0001;
				end
			end
			default: next_st.sr = OCSP_IDLE;
			endcase
		end

		// Receive buffer, multiplexer to terminal
		if (mux_rx_valid && !std_mode &&
			st.rx_cnt == (AW+1)'(DEPTH)) begin
			next_st.rx_cnt = '0;
			next_st.rx_rd = st.rx_wr;
			next_st.rx_ovf = 1'b1;
		end else begin
			if (mux_rx_valid && !std_mode) begin
				next_st.rxm[st.rx_wr] = mux_rx_data;
				next_st.rx_wr = st.rx_wr + 1'b1;
			end
			if (sr_pop)
				next_st.rx_rd = st.rx_rd + 1'b1;
			next_st.rx_cnt = st.rx_cnt
				+ (AW+1)'(mux_rx_valid && !std_mode)
				- (AW+1)'(sr_pop);
		end
	end

	// Buffers are plain flops; reset clears them and the counters, sets cts, rxd and sync_tx high and both state machines to idle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= '0;
			st.cts <= 1'b1;
			st.ds <= OCSP_IDLE;
			st.sr <= OCSP_IDLE;
			st.rxd <= 1'b1;
			st.sync_tx <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		term_rxd = st.rxd;
		unique case (eff_type)
		OCSP_IF_ALWAYS_ON: term_rxd_oe = 1'b1;
		OCSP_IF_RS232:     term_rxd_oe = 1'b1;
		default:           term_rxd_oe = std_mode || st.sr != OCSP_IDLE;
		endcase
		term_cts = (!flow_on || cts_force) ? 1'b1 : st.cts;
		if (!flow_on || dsr_force)
			term_dsr = 1'b1;
		else
			term_dsr = (dtr_ignore || term_dtr)
				&& (st.rx_cnt != '0 || st.sr != OCSP_IDLE)
				&& demod_lock && !mux_alarm;
		mux_tx_valid = !std_mode && st.tx_cnt != '0;
		mux_tx_data = st.txm[st.tx_rd];
		mux_sync_tx = st.sync_tx;
		parity_error = st.perr;
		framing_error = st.ferr;
		tx_overflow = st.tx_ovf;
		rx_overflow = st.rx_ovf;
		tx_fill = st.tx_cnt;
		rx_fill = st.rx_cnt;
	end
endmodule
`default_nettype wire

// ---- verification/ocsp_port_sva.sv ----
// Concurrent checks on the overhead channel serial port outputs
`timescale 1ns/1ps
`default_nettype none
module ocsp_port_sva
	import ocsp_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input wire logic	clk,
	input wire logic	reset,
	input wire logic [1:0]	frame_mode,
	input wire logic [1:0]	iface_type,
	input wire logic	term_txd,
	input wire logic	mux_sync_tx,
	input wire logic	flow_enable,
	input wire logic	cts_force,
	input wire logic	dsr_force,
	input wire logic	demod_lock,
	input wire logic	mux_alarm,
	input wire logic	term_rxd,
	input wire logic	term_rxd_oe,
	input wire logic	term_cts,
	input wire logic	term_dsr,
	input wire logic	mux_sync_rx,
	input wire logic [$clog2(DEPTH):0]	tx_fill
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic	flow_on;
	assign flow_on = flow_enable && iface_type == OCSP_IF_RS232;
	// Three cycles leave room for the registered fill count
	sequence s_full;
		flow_on && !cts_force && tx_fill >= DEPTH * 3 / 4;
	endsequence
	sequence s_low;
		flow_on && !cts_force && tx_fill <= DEPTH / 4;
	endsequence
	sequence s_std;
		frame_mode == OCSP_MODE_STD;
	endsequence
	drive_on_a: assert property (
		iface_type == OCSP_IF_ALWAYS_ON |-> term_rxd_oe)
		else $error("driver off in always-on setting");
	std_drive_a: assert property (s_std |-> term_rxd_oe)
		else $error("driver off in standard mode");
	cts_drop_a: assert property (s_full[*3] |-> !term_cts)
		else $error("clear to send kept at high fill");
	cts_rise_a: assert property (s_low[*3] |-> term_cts)
		else $error("clear to send kept low at low fill");
	cts_forced_a: assert property (
		cts_force || !flow_on |-> term_cts)
		else $error("clear to send not forced");
	dsr_forced_a: assert property (
		dsr_force || !flow_on |-> term_dsr)
		else $error("set ready not forced");
	dsr_fault_a: assert property (
		flow_on && !dsr_force && (!demod_lock || mux_alarm) |-> !term_dsr)
		else $error("set ready kept on fault");
	std_pass_a: assert property (
		s_std ##1 s_std |-> term_rxd == $past(mux_sync_rx))
		else $error("standard mode bit not passed through");
	sync_out_a: assert property (
		mux_sync_tx == $past(term_txd))
		else $error("terminal bit not passed to frame");
endmodule
bind ocsp_port ocsp_port_sva #(.DEPTH(DEPTH)) i_sva (
	.clk(clk),
	.reset(reset),
	.frame_mode(frame_mode),
	.iface_type(iface_type),
	.term_txd(term_txd),
	.mux_sync_tx(mux_sync_tx),
	.flow_enable(flow_enable),
	.cts_force(cts_force),
	.dsr_force(dsr_force),
	.demod_lock(demod_lock),
	.mux_alarm(mux_alarm),
	.term_rxd(term_rxd),
	.term_rxd_oe(term_rxd_oe),
	.term_cts(term_cts),
	.term_dsr(term_dsr),
	.mux_sync_rx(mux_sync_rx),
	.tx_fill(tx_fill)
);
`default_nettype wire

// ---- verification/ocsp_term_model.sv ----
// Terminal equipment model sending characters into the port
`timescale 1ns/1ps
`default_nettype none
module ocsp_term_model #(
	parameter int DIV = 8
) (
	input  wire logic	clk,
	input  wire logic	cts,
	output logic	txd
);
	initial txd = 1'b1;
	// Eight data bits, no parity, one stop; bad_stop breaks the frame
	task automatic send(input logic [7:0] d, input logic bad_stop);
		int n;
		n = 0;
		while (cts !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		txd = 1'b0;
		repeat (DIV) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			txd = d[i];
			repeat (DIV) @(negedge clk);
		end
		txd = !bad_stop;
		repeat (DIV) @(negedge clk);
		txd = 1'b1;
		repeat (DIV) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the overhead channel serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ocsp_pkg::*;
	localparam int DIV = 8;
	logic	clk = 1'b0, reset = 1'b1;
	logic [1:0]	frame_mode = OCSP_MODE_ENH, iface_type = OCSP_IF_RS232;
	logic [15:0]	bit_div = 16'(DIV);
	logic [1:0]	data_bits = 2'h3;
	logic	parity_en = 1'b0, parity_odd = 1'b0, stop_two = 1'b0;
	logic	flow_enable = 1'b1, cts_force = 1'b0, dsr_force = 1'b0;
	logic	dtr_ignore = 1'b0, mux_alarm = 1'b0, demod_lock = 1'b1;
	logic	term_rts = 1'b1, term_dtr = 1'b1, mux_tx_ready = 1'b1;
	logic	mux_rx_valid = 1'b0, mux_sync_rx = 1'b1, rx_mon = 1'b1;
	logic [7:0]	mux_rx_data = 8'h00, b, rxb, mux_tx_data;
	logic	term_txd, term_rxd, term_rxd_oe, term_cts, term_dsr;
	logic	mux_tx_valid, mux_sync_tx, parity_error, framing_error;
	logic	tx_overflow, rx_overflow;
	logic [4:0]	tx_fill, rx_fill;
	logic [7:0]	txq[$], rxq[$];
	int	n_mismatch = 0, checks_done = 0, n_frame = 0, n, n_ovf = 0;
	ocsp_port #(.DEPTH(16)) i_dut (.*);
	ocsp_term_model #(.DIV(DIV)) i_term (.clk(clk), .cts(term_cts),
		.txd(term_txd));
	always #2 clk = ~clk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic step(input int c);
		repeat (c) @(negedge clk);
	endtask
	// Popped byte sampled before the edge that takes it
	always @(negedge clk) begin
		#1;
		if (!reset && mux_tx_valid === 1'b1 && mux_tx_ready === 1'b1)
			chk({8'h00, mux_tx_data}, {8'h00, txq.pop_front()});
	end
	always @(negedge clk) if (framing_error === 1'b1) n_frame++;
	always @(negedge clk) if (rx_overflow === 1'b1) n_ovf++;
	always begin
		@(negedge term_rxd);
		if (rx_mon && !reset) begin
			step(DIV / 2);
			for (int i = 0; i < 8; i++) begin
				step(DIV);
				rxb[i] = term_rxd;
			end
			step(DIV);
			chk({7'h00, term_rxd, rxb}, {8'h01, rxq.pop_front()});
		end
	end
	initial begin
		step(60000);
		n_mismatch++;
		complete_run();
	end
	initial begin
		void'($urandom(32'ha5ac));
		step(8);
		reset = 1'b0;
		for (int i = 0; i < 3; i++) begin
			b = 8'($urandom);
			txq.push_back(b);
			i_term.send(b, 1'b0);
		end
		i_term.send(8'h5a, 1'b1);
		term_rts = 1'b0;
		i_term.send(8'h33, 1'b0);
		term_rts = 1'b1;
		chk(16'(n_frame), 16'h0001);
		chk(16'(txq.size()), 16'h0000);
		$display("test terminal_in done");
		mux_tx_ready = 1'b0;
		for (int i = 0; i < 12; i++) begin
			b = 8'($urandom);
			txq.push_back(b);
			i_term.send(b, 1'b0);
		end
		chk({11'h000, tx_fill}, 16'h000c);
		chk({15'h0000, term_cts}, 16'h0000);
		cts_force = 1'b1;
		step(1);
		chk({15'h0000, term_cts}, 16'h0001);
		cts_force = 1'b0;
		mux_tx_ready = 1'b1;
		step(4);
		mux_tx_ready = 1'b0;
		chk({11'h000, tx_fill}, 16'h0008);
		chk({15'h0000, term_cts}, 16'h0000);
		mux_tx_ready = 1'b1;
		for (n = 0; tx_fill !== 5'h00 && n < 100; n++) step(1);
		if (n >= 100) begin
			n_mismatch++;
			complete_run();
		end
		step(2);
		chk({15'h0000, term_cts}, 16'h0001);
		$display("test clear_to_send done");
		term_dtr = 1'b0;
		step(1);
		chk({15'h0000, term_dsr}, 16'h0000);
		dsr_force = 1'b1;
		step(1);
		chk({15'h0000, term_dsr}, 16'h0001);
		dsr_force = 1'b0;
		for (int i = 0; i < 2; i++) begin
			b = 8'($urandom);
			rxq.push_back(b);
			mux_rx_data = b;
			mux_rx_valid = 1'b1;
			step(1);
		end
		mux_rx_valid = 1'b0;
		step(4 * DIV);
		chk({11'h000, rx_fill}, 16'h0002);
		dtr_ignore = 1'b1;
		step(2);
		chk({15'h0000, term_dsr}, 16'h0001);
		demod_lock = 1'b0;
		step(1);
		chk({15'h0000, term_dsr}, 16'h0000);
		demod_lock = 1'b1;
		mux_alarm = 1'b1;
		step(1);
		chk({15'h0000, term_dsr}, 16'h0000);
		mux_alarm = 1'b0;
		step(25 * DIV);
		chk(16'(rxq.size()), 16'h0000);
		term_dtr = 1'b1;
		dtr_ignore = 1'b0;
		$display("test receive_hold done");
		iface_type = OCSP_IF_GATED_4W;
		step(1);
		chk({15'h0000, term_rxd_oe}, 16'h0000);
		// Echo test: an all-ones character is only a start bit on the line
		for (int k = 0; k < 2; k++) begin
			iface_type = k == 0 ? OCSP_IF_TWO_WIRE : OCSP_IF_ALWAYS_ON;
			if (k == 1) txq.push_back(8'hff);
			b = 8'($urandom);
			rxq.push_back(b);
			mux_rx_data = b;
			mux_rx_valid = 1'b1;
			step(1);
			mux_rx_valid = 1'b0;
			step(2 * DIV);
			i_term.send(8'hff, 1'b0);
			step(12 * DIV);
		end
		chk(16'(txq.size() + rxq.size()), 16'h0000);
		$display("test wire_modes done");
		// DTR hold keeps the buffer filling until it overflows
		iface_type = OCSP_IF_RS232;
		term_dtr = 1'b0;
		mux_rx_valid = 1'b1;
		for (int i = 0; i < 17; i++) begin
			mux_rx_data = 8'($urandom);
			step(1);
		end
		mux_rx_valid = 1'b0;
		step(2);
		chk({11'h000, rx_fill}, 16'h0000);
		chk(16'(n_ovf), 16'h0001);
		term_dtr = 1'b1;
		$display("test overflow done");
		rx_mon = 1'b0;
		frame_mode = OCSP_MODE_STD;
		for (int i = 0; i < 64; i++) begin
			b = 8'($urandom);
			mux_sync_rx = b[0];
			step(1);
			chk({15'h0000, term_rxd_oe}, 16'h0001);
		end
		$display("test standard_mode done");
		complete_run();
	end
endmodule
`default_nettype wire
